// ### hdl/tss_pkg.sv
package tss_pkg;

  // Trigger response selections
  typedef enum logic [1:0] {
    TSS_RESP_NONE,
    TSS_RESP_SINGLE,
    TSS_RESP_PER_TRIG,
    TSS_RESP_PULSE
  } tss_resp_e;

  // Shutter setting selections
  typedef enum logic [1:0] {
    TSS_SHUT_NORMAL,
    TSS_SHUT_CLOSED,
    TSS_SHUT_OPEN,
    TSS_SHUT_OPEN_BEFORE
  } tss_shut_e;

  // Edge polarity codes
  localparam logic TSS_EDGE_RISING = 1'b0;
  localparam logic TSS_EDGE_FALLING = 1'b1;

  // Clock and default shutter compensation times
  localparam int TSS_CLK_MHZ = 125;
  localparam int TSS_OPEN_DELAY_US = 8;
  localparam int TSS_CLOSE_DELAY_US = 8;
  localparam int TSS_OPEN_CYC = TSS_OPEN_DELAY_US * TSS_CLK_MHZ;
  localparam int TSS_CLOSE_CYC = TSS_CLOSE_DELAY_US * TSS_CLK_MHZ;
  localparam int TSS_CNT_W = 32;

endpackage

// ### hdl/tss_edge_detect.sv
`timescale 1ns/10ps
// Synchronises the trigger pin and reports both edges
module tss_edge_detect
  import tss_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic pin,
  input wire logic edge_select,
  output logic level,
  output logic start_edge,
  output logic end_edge
);

  logic sync1_reg; // First stage, read only by second
  logic sync2_reg; // Second stage
  logic prev_reg; // Delayed copy for edge finding
  logic rise;
  logic fall;

  // Two-flop synchroniser plus history
  // Reset lets the pin flow through, so the history already matches the
  // pin's idle level at release and no false edge follows reset
  always_ff @(posedge clock) begin
    if (srst || clk_en) begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;
  assign level = sync2_reg;
  // Polarity swaps which edge starts and which ends
  assign start_edge = clk_en & ((edge_select == TSS_EDGE_RISING) ? rise
                                                                  : fall);
  assign end_edge = clk_en & ((edge_select == TSS_EDGE_RISING) ? fall
                                                                : rise);

endmodule // tss_edge_detect

// ### hdl/tss_sequencer.sv
`timescale 1ns/10ps
// Full-frame acquisition sequencer: trigger, shutter and readout start
module tss_sequencer
  import tss_pkg::*;
#(
  parameter int CNT_W = TSS_CNT_W,
  parameter int OPEN_CYC = TSS_OPEN_CYC,
  parameter int CLOSE_CYC = TSS_CLOSE_CYC
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic trigger_in,
  input wire logic [1:0] trigger_response,
  input wire logic [1:0] shutter_mode,
  input wire logic trigger_edge_select,
  input wire logic [CNT_W-1:0] exposure_cycles,
  input wire logic [15:0] frame_count,
  input wire logic acq_start,
  input wire logic acq_stop,
  input wire logic readout_done,
  output logic shutter_drive,
  output logic readout_start,
  output logic exposing,
  output logic waiting_trigger,
  output logic acquiring,
  output logic trigger_dropped
);

  typedef enum logic [2:0] {
    TSS_IDLE,
    TSS_WAIT_TRIG,
    TSS_OPENING,
    TSS_EXPOSE,
    TSS_CLOSING,
    TSS_READOUT
  } tss_state_e;

  tss_state_e state_reg; // Main sequencer state
  tss_state_e state_next;
  logic [CNT_W-1:0] timer_reg; // Shared delay and exposure counter
  logic [15:0] frames_left_reg; // Frames still to acquire
  logic armed_reg; // Single-trigger sequence released
  logic readout_start_reg;
  logic trig_start;
  logic trig_end;
  logic busy;
  logic timer_done;
  tss_resp_e resp;
  tss_shut_e shut;

  assign resp = tss_resp_e'(trigger_response);
  assign shut = tss_shut_e'(shutter_mode);

  tss_edge_detect u_edge (
    .clock(clock),
    .srst(srst),
    .clk_en(clk_en),
    .pin(trigger_in),
    .edge_select(trigger_edge_select),
    .level(),
    .start_edge(trig_start),
    .end_edge(trig_end)
  );

  // Saturating compare, zero exposure still takes one cycle
  function automatic logic reached(input logic [CNT_W-1:0] cnt,
                                   input logic [CNT_W-1:0] lim);
    reached = (cnt + 1'b1 >= lim);
  endfunction

  // Delay in each timed state; shutter delays skipped if not moving
  function automatic logic [CNT_W-1:0] state_limit(input tss_state_e st,
                                                   input tss_shut_e sh,
                                                   input logic [CNT_W-1:0] expo);
    state_limit = '0;
    if (st == TSS_OPENING && sh == TSS_SHUT_NORMAL) begin
      state_limit = CNT_W'(OPEN_CYC);
    end else if (st == TSS_CLOSING && (sh == TSS_SHUT_NORMAL ||
                                       sh == TSS_SHUT_OPEN_BEFORE)) begin
      state_limit = CNT_W'(CLOSE_CYC);
    end else if (st == TSS_EXPOSE) begin
      state_limit = expo;
    end
  endfunction

  // Exposure passed in, so the assignment follows changes to it
  assign timer_done = reached(timer_reg,
                              state_limit(state_reg, shut, exposure_cycles));
  // Anything past waiting is busy; triggers then are discarded
  assign busy = (state_reg != TSS_IDLE) && (state_reg != TSS_WAIT_TRIG);

  // Does this frame need a trigger edge to begin?
  function automatic logic needs_trigger(input tss_resp_e r,
                                         input logic armed);
    case (r)
      TSS_RESP_NONE: needs_trigger = 1'b0;
      TSS_RESP_SINGLE: needs_trigger = ~armed;
      default: needs_trigger = 1'b1;
    endcase
  endfunction

  // Next-state decode
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      TSS_IDLE: begin
        if (acq_start) begin
          state_next = TSS_WAIT_TRIG;
        end
      end
      TSS_WAIT_TRIG: begin
        // Trigger ignored unless mode wants one
        if (acq_stop || frames_left_reg == 16'h0000) begin
          state_next = TSS_IDLE;
        end else if (!needs_trigger(resp, armed_reg)) begin
          state_next = TSS_OPENING;
        end else if (trig_start) begin
          // Pulse mode skips the timed shutter opening delay
          state_next = (resp == TSS_RESP_PULSE) ? TSS_EXPOSE
                                                : TSS_OPENING;
        end
      end
      TSS_OPENING: begin
        if (timer_done) begin
          state_next = TSS_EXPOSE;
        end
      end
      TSS_EXPOSE: begin
        // Pulse mode ends on the opposite edge, not on the timer
        if (resp == TSS_RESP_PULSE ? trig_end : timer_done) begin
          state_next = TSS_CLOSING;
        end
      end
      TSS_CLOSING: begin
        if (timer_done) begin
          state_next = TSS_READOUT;
        end
      end
      TSS_READOUT: begin
        if (readout_done) begin
          state_next = TSS_WAIT_TRIG;
        end
      end
      // Unused state codes fall back to idle
      default: state_next = TSS_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= TSS_IDLE;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // Timer restarts on each state change
  always_ff @(posedge clock) begin
    if (srst) begin
      timer_reg <= '0;
    end else if (clk_en) begin
      if (state_next != state_reg) begin
        timer_reg <= '0;
      end else if (!timer_done) begin
        timer_reg <= timer_reg + 1'b1;
      end
    end
  end

  // Frame budget, zero means run until stopped
  always_ff @(posedge clock) begin
    if (srst) begin
      frames_left_reg <= 16'h0000;
    end else if (clk_en) begin
      if (state_reg == TSS_IDLE && acq_start) begin
        frames_left_reg <= (frame_count == 16'h0000) ? 16'hffff
                                                     : frame_count;
      end else if (state_reg == TSS_READOUT && readout_done &&
                   frame_count != 16'h0000) begin
        frames_left_reg <= frames_left_reg - 16'h0001;
      end
    end
  end

  // Single-trigger arming: one edge releases the whole sequence
  always_ff @(posedge clock) begin
    if (srst) begin
      armed_reg <= 1'b0;
    end else if (clk_en) begin
      if (state_reg == TSS_IDLE) begin
        armed_reg <= 1'b0;
      end else if (state_reg == TSS_WAIT_TRIG && trig_start) begin
        armed_reg <= 1'b1;
      end
    end
  end

  // Readout start pulse, only after the closing phase ends
  always_ff @(posedge clock) begin
    if (srst) begin
      readout_start_reg <= 1'b0;
    end else if (clk_en) begin
      readout_start_reg <= (state_reg == TSS_CLOSING) &&
                           (state_next == TSS_READOUT);
    end else begin
      readout_start_reg <= 1'b0;
    end
  end

  // Busy trigger report; edge discarded, never stored
  always_ff @(posedge clock) begin
    if (srst) begin
      trigger_dropped <= 1'b0;
    end else if (clk_en) begin
      trigger_dropped <= busy & trig_start &
                         (resp != TSS_RESP_NONE);
    end
  end

  // Shutter drive per setting
  always_ff @(posedge clock) begin
    if (srst) begin
      shutter_drive <= 1'b0;
    end else if (clk_en) begin
      unique case (shut)
        TSS_SHUT_CLOSED: shutter_drive <= 1'b0;
        TSS_SHUT_OPEN: shutter_drive <= 1'b1;
        TSS_SHUT_NORMAL: begin
          shutter_drive <= (state_next == TSS_OPENING) ||
                           (state_next == TSS_EXPOSE);
        end
        TSS_SHUT_OPEN_BEFORE: begin
          // Held open while waiting; drops to close then read, and in idle
          shutter_drive <= (state_next == TSS_WAIT_TRIG) ||
                           (state_next == TSS_OPENING) ||
                           (state_next == TSS_EXPOSE);
        end
      endcase
    end
  end

  assign readout_start = readout_start_reg;
  assign exposing = (state_reg == TSS_EXPOSE);
  assign waiting_trigger = (state_reg == TSS_WAIT_TRIG) &&
                           needs_trigger(resp, armed_reg);
  assign acquiring = (state_reg != TSS_IDLE);

endmodule // tss_sequencer

// ### sim/tss_seq_sva.sv
`timescale 1ns/10ps
// Output relations of the sequencer, seen at its ports
module tss_seq_sva
  import tss_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [1:0] trigger_response,
  input wire logic [1:0] shutter_mode,
  input wire logic shutter_drive,
  input wire logic readout_start,
  input wire logic exposing,
  input wire logic waiting_trigger,
  input wire logic acquiring,
  input wire logic trigger_dropped
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // Fixed settings act one cycle after they are applied
  shut_closed_a: assert property (shutter_mode == TSS_SHUT_CLOSED &&
    $past(shutter_mode) == TSS_SHUT_CLOSED |-> !shutter_drive)
    else $error("shutter open in closed setting");
  shut_open_a: assert property (!$past(srst) &&
    shutter_mode == TSS_SHUT_OPEN && $past(shutter_mode) == TSS_SHUT_OPEN
    |-> shutter_drive) else $error("shutter shut in open setting");
  none_ignore_a: assert property (trigger_response == TSS_RESP_NONE &&
    $past(trigger_response) == TSS_RESP_NONE
    |-> !trigger_dropped && !waiting_trigger) else $error("trigger seen");
  // Pulse mode skips the opening phase, so it is left out
  expose_open_a: assert property (exposing &&
    shutter_mode == TSS_SHUT_NORMAL && trigger_response != TSS_RESP_PULSE
    |-> shutter_drive) else $error("exposing with shutter shut");
  read_closed_a: assert property (readout_start &&
    shutter_mode != TSS_SHUT_OPEN |-> !shutter_drive && !exposing)
    else $error("readout with shutter open");
  read_pulse_a: assert property (readout_start |=> !readout_start)
    else $error("readout start too long");
  drop_busy_a: assert property (trigger_dropped |-> $past(acquiring))
    else $error("drop while idle");
  reopen_wait_a: assert property (waiting_trigger &&
    $past(waiting_trigger) && shutter_mode == TSS_SHUT_OPEN_BEFORE &&
    $past(shutter_mode) == TSS_SHUT_OPEN_BEFORE |-> shutter_drive)
    else $error("shutter shut while waiting");
  cover property (readout_start);
  cover property (trigger_dropped);
  cover property (exposing && trigger_response == TSS_RESP_PULSE);
endmodule // tss_seq_sva

bind tss_sequencer tss_seq_sva chk (.clock(clock), .srst(srst),
  .trigger_response(trigger_response), .shutter_mode(shutter_mode),
  .shutter_drive(shutter_drive), .readout_start(readout_start),
  .exposing(exposing), .waiting_trigger(waiting_trigger),
  .acquiring(acquiring), .trigger_dropped(trigger_dropped));

// ### sim/tss_partner.sv
`timescale 1ns/10ps
// Trigger source and readout engine beside the sequencer
module tss_partner (
  input wire logic clock,
  input wire logic fire,
  input wire logic [7:0] width,
  input wire logic idle_lvl,
  input wire logic [3:0] lag,
  input wire logic readout_start,
  output logic trigger_in,
  output logic readout_done
);
  int tc = 0; // Pulse cycles left
  int rc = 0; // Readout cycles left
  // Counts move on the rising edge
  always @(posedge clock) begin
    if (fire) tc <= width;
    else if (tc > 0) tc <= tc - 1;
    if (readout_start) rc <= lag;
    else if (rc > 0) rc <= rc - 1;
  end
  // Pins change on the falling edge
  always @(negedge clock) begin
    trigger_in <= (tc > 0) ? !idle_lvl : idle_lvl;
    readout_done <= (rc == 1);
  end
endmodule // tss_partner

// ### sim/tss_sequencer_tb.sv
`timescale 1ns/10ps
// Mode by mode checks of the sequencer
module tss_sequencer_tb;
  import tss_pkg::*;
  logic clock = 1'b0, srst = 1'b1, fire = 1'b0, idle_lvl = 1'b0;
  logic trigger_in, readout_done, trigger_edge_select = 1'b0;
  logic [1:0] trigger_response = 2'h0, shutter_mode = 2'h0;
  logic acq_start = 1'b0;
  logic [31:0] exposure_cycles = 32'h5;
  logic [15:0] frame_count = 16'h2;
  logic [7:0] width = 8'h4;
  logic [3:0] lag = 4'h1;
  logic shutter_drive, readout_start, exposing;
  logic waiting_trigger, acquiring, trigger_dropped;
  int err_total = 0, samples_checked = 0;
  int n_rd = 0, n_exp = 0, n_sh = 0, n_dr = 0;
  tss_sequencer #(.CNT_W(32), .OPEN_CYC(4), .CLOSE_CYC(4)) uut (
    .clock(clock), .srst(srst), .clk_en(1'b1), .trigger_in(trigger_in),
    .trigger_response(trigger_response), .shutter_mode(shutter_mode),
    .trigger_edge_select(trigger_edge_select),
    .exposure_cycles(exposure_cycles), .frame_count(frame_count),
    .acq_start(acq_start), .acq_stop(1'b0), .readout_done(readout_done),
    .shutter_drive(shutter_drive), .readout_start(readout_start),
    .exposing(exposing), .waiting_trigger(waiting_trigger),
    .acquiring(acquiring), .trigger_dropped(trigger_dropped));
  tss_partner far (.clock(clock), .fire(fire), .width(width),
    .idle_lvl(idle_lvl), .lag(lag), .readout_start(readout_start),
    .trigger_in(trigger_in), .readout_done(readout_done));
  initial forever #4 clock = ~clock;
  // Event tallies, cleared at each start
  always @(posedge clock) begin
    if (readout_start === 1'b1) n_rd++;
    if (exposing === 1'b1) n_exp++;
    if (shutter_drive === 1'b1) n_sh++;
    if (trigger_dropped === 1'b1) n_dr++;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic chk(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %b want %b", $time, got, exp);
    end
  endtask
  task automatic go(input logic [1:0] r, s, input logic [15:0] f);
    trigger_response = r;
    shutter_mode = s;
    frame_count = f;
    {n_rd, n_exp, n_sh, n_dr} = '0;
    acq_start = 1'b1;
    tick(1);
    acq_start = 1'b0;
    tick(2);
  endtask
  task automatic pulse(input logic [7:0] w);
    width = w;
    fire = 1'b1;
    tick(1);
    fire = 1'b0;
  endtask
  // Untriggered runs in the normal, closed and open shutter settings
  task automatic t_none(input logic [1:0] s);
    go(TSS_RESP_NONE, s, 2);
    pulse(8'h4);
    tick(120);
    chk(n_rd == 2 && n_dr == 0, 1'b1);
    chk(n_sh > 0, s != TSS_SHUT_CLOSED);
  endtask
  task automatic t_single;
    go(TSS_RESP_SINGLE, TSS_SHUT_NORMAL, 3);
    tick(40);
    chk(n_rd == 0 && waiting_trigger, 1'b1);
    pulse(8'h4);
    tick(150);
    chk(n_rd == 3 && !acquiring, 1'b1);
  endtask
  // Falling edge, a second trigger lands during the closing delay
  task automatic t_per;
    trigger_edge_select = 1'b1;
    idle_lvl = 1'b1;
    tick(6);
    go(TSS_RESP_PER_TRIG, TSS_SHUT_NORMAL, 2);
    pulse(8'h4);
    tick(9);
    pulse(8'h2);
    tick(60);
    chk(n_rd == 1 && waiting_trigger, 1'b1);
    chk(n_dr > 0, 1'b1);
    chk(n_exp == 5 && n_sh == 9, 1'b1);
    pulse(8'h4);
    tick(60);
    chk(n_rd == 2 && !acquiring, 1'b1);
    trigger_edge_select = 1'b0;
    idle_lvl = 1'b0;
    tick(6);
  endtask
  // Slow readout, shutter open between frames
  task automatic t_openb;
    lag = 4'h6;
    go(TSS_RESP_PER_TRIG, TSS_SHUT_OPEN_BEFORE, 2);
    tick(5);
    chk(shutter_drive, 1'b1);
    pulse(8'h4);
    tick(40);
    chk(n_rd == 1 && waiting_trigger, 1'b1);
    chk(shutter_drive, 1'b1);
    pulse(8'h4);
    tick(40);
    chk(n_rd == 2 && !acquiring, 1'b1);
    lag = 4'h1;
  endtask
  // Exposure length set by the pulse, both polarities
  task automatic t_pulse;
    go(TSS_RESP_PULSE, TSS_SHUT_NORMAL, 2);
    pulse(8'h14);
    tick(40);
    chk(n_exp >= 19 && n_exp <= 21, 1'b1);
    trigger_edge_select = 1'b1;
    idle_lvl = 1'b1;
    tick(6);
    n_exp = 0;
    pulse(8'h1e);
    tick(50);
    chk(n_exp >= 29 && n_exp <= 31 && !acquiring, 1'b1);
  endtask
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    tick(20);
    srst = 1'b0;
    tick(2);
    t_none(TSS_SHUT_NORMAL);
    t_none(TSS_SHUT_CLOSED);
    t_none(TSS_SHUT_OPEN);
    t_single;
    t_per;
    t_openb;
    t_pulse;
    end_of_test();
  end
  // Runaway guard, far beyond the planned run
  initial begin
    #100000;
    err_total++;
    end_of_test();
  end
endmodule // tss_sequencer_tb
